// ===== fwd_pkg.sv
// Package with constants and types for the learning switch forwarding core
package fwd_pkg;
   localparam int TABLE_DEPTH = 4096;
   localparam int AGE_BITS = 2;
   localparam logic [1:0] AGE_FRESH = 2'h3;
   localparam logic [1:0] AGE_NONE = 2'h0;
   localparam logic [47:0] MULTICAST_MASK = 48'h010000000000;
   localparam logic [47:0] BROADCAST_ADDR = 48'hFFFFFFFFFFFF;
   localparam real AGE_TICK_US = 1000.0;
   localparam real CLK_PERIOD_NS = 10.0;
   localparam int AGE_TICK_CYCLES = int'(AGE_TICK_US * 1000.0 / CLK_PERIOD_NS);
   localparam real ACT_HOLD_MS = 50.0;
   localparam int ACT_HOLD_CYCLES = int'(ACT_HOLD_MS * 1000000.0 / CLK_PERIOD_NS);
   // Ability bits: [3]=100 full, [2]=100 half, [1]=10 full, [0]=10 half
   localparam int ABIL_100F = 3;
   localparam int ABIL_100H = 2;
   localparam int ABIL_10F = 1;
   localparam int ABIL_10H = 0;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_LOOKUP = 4'h2,
      ST_UPDATE = 4'h4,
      ST_SCRUB = 4'h8
   } fwd_state_t;
endpackage

// ===== port_cfg_if.sv
// Interface carrying per-port resolved link state, duplex and speed
`timescale 1ns/1ps
`default_nettype none
interface port_cfg_if #(parameter int PORTS = 16);
   logic [PORTS-1:0] link_up;
   logic [PORTS-1:0] full_duplex;
   logic [PORTS-1:0] speed_100;
   modport resolver (output link_up, full_duplex, speed_100);
   modport user (input link_up, full_duplex, speed_100);
endinterface
`default_nettype wire

// ===== port_mode_resolve.sv
// Per-port speed and duplex resolution from settings and negotiation results
`timescale 1ns/1ps
`default_nettype none
module port_mode_resolve #(
   parameter int PORTS = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [PORTS-1:0] fixed_speed_sel,
   input wire logic [PORTS-1:0] fixed_full_sel,
   input wire logic [PORTS-1:0] phy_link,
   input wire logic [PORTS-1:0] partner_negotiates,
   input wire logic [4*PORTS-1:0] partner_abil,
   input wire logic [PORTS-1:0] idle_is_100,
   port_cfg_if.resolver cfg
);
   logic [PORTS-1:0] s1_link, s2_link, s1_neg, s2_neg, s1_idle, s2_idle;
   logic [4*PORTS-1:0] s1_abil, s2_abil;
   logic [PORTS-1:0] next_full, next_100;

   // Pins are asynchronous to mclk
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_link <= '0; s2_link <= '0; s1_neg <= '0; s2_neg <= '0;
         s1_idle <= '0; s2_idle <= '0; s1_abil <= '0; s2_abil <= '0;
      end else begin
         s1_link <= phy_link; s2_link <= s1_link;
         s1_neg <= partner_negotiates; s2_neg <= s1_neg;
         s1_idle <= idle_is_100; s2_idle <= s1_idle;
         s1_abil <= partner_abil; s2_abil <= s1_abil;
      end
   end

   always_comb begin
      for (int p = 0; p < PORTS; p++) begin
         logic [3:0] a;
         a = s2_abil[4*p +: 4];
         if (fixed_speed_sel[p]) begin
            next_100[p] = 1'b1;
            next_full[p] = fixed_full_sel[p];
         end else if (!s2_neg[p]) begin
            next_100[p] = s2_idle[p];
            next_full[p] = 1'b0;
         end else begin
            // Our own port advertises all four modes, so the partner's set is the common set
            next_100[p] = a[fwd_pkg::ABIL_100F] | a[fwd_pkg::ABIL_100H];
            next_full[p] = a[fwd_pkg::ABIL_100F] |
               (~a[fwd_pkg::ABIL_100H] & a[fwd_pkg::ABIL_10F]);
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg.link_up <= '0;
         cfg.full_duplex <= '0;
         cfg.speed_100 <= '0;
      end else begin
         cfg.link_up <= s2_link;
         cfg.full_duplex <= next_full & s2_link;
         cfg.speed_100 <= next_100 & s2_link;
      end
   end
endmodule
`default_nettype wire

// ===== learning_switch_forwarding.sv
// Forwarding decision, address learning with aging, and port indicators
`timescale 1ns/1ps
`default_nettype none
module learning_switch_forwarding #(
   parameter int PORTS = 16,
   parameter int DEPTH = fwd_pkg::TABLE_DEPTH,
   parameter int AGE_TICK = fwd_pkg::AGE_TICK_CYCLES,
   parameter int ACT_HOLD = fwd_pkg::ACT_HOLD_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   // Frame descriptor presented once the frame is fully received
   input wire logic frame_done,
   input wire logic frame_bad,
   input wire logic [$clog2(PORTS)-1:0] frame_port,
   input wire logic [47:0] frame_dst,
   input wire logic [47:0] frame_src,
   output logic frame_ready,
   output logic fwd_valid,
   output logic [PORTS-1:0] fwd_mask,
   input wire logic [PORTS-1:0] tx_frame,
   input wire logic [PORTS-1:0] rx_frame,
   // Port mode settings, speed_auto is the inverse of a fixed-speed select
   input wire logic [PORTS-1:0] fixed_speed_sel,
   input wire logic [PORTS-1:0] fixed_full_sel,
   input wire logic [PORTS-1:0] phy_link,
   input wire logic [PORTS-1:0] partner_negotiates,
   input wire logic [4*PORTS-1:0] partner_abil,
   input wire logic [PORTS-1:0] idle_is_100,
   output logic [PORTS-1:0] link_up_indicator,
   output logic [PORTS-1:0] activity_indicator,
   output logic [PORTS-1:0] duplex_indicator,
   output logic [PORTS-1:0] speed_indicator,
   output logic table_busy
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = $clog2(PORTS);
   localparam int TW = 48 - AW;
   localparam int TICK_W = $clog2(AGE_TICK + 1);
   localparam int ACT_W = $clog2(ACT_HOLD + 1);

   // Direct-mapped table: the index comes from low address bits, the tag holds the rest
   logic [TW-1:0] tag_mem [DEPTH];
   logic [PW-1:0] port_mem [DEPTH];
   logic [fwd_pkg::AGE_BITS-1:0] age_mem [DEPTH];

   fwd_pkg::fwd_state_t state, next_state;
   logic [AW-1:0] scrub_idx;
   logic [TICK_W-1:0] tick_cnt;
   logic age_pend;
   logic [47:0] dst_q, src_q;
   logic [PW-1:0] port_q;
   logic bad_q;
   logic [PORTS-1:0] mask_q;
   logic [ACT_W-1:0] act_cnt [PORTS];
   logic [PORTS-1:0] tx_s1, tx_s2, rx_s1, rx_s2;
   logic [PORTS-1:0] speed_set, duplex_set;

   // Settings pass a reset register so every port starts in auto-negotiation,
   // whatever the settings inputs show while reset is applied
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         speed_set <= '0;
         duplex_set <= '0;
      end else begin
         speed_set <= fixed_speed_sel;
         duplex_set <= fixed_full_sel;
      end
   end

   port_cfg_if #(.PORTS(PORTS)) cfg ();

   port_mode_resolve #(.PORTS(PORTS)) u_resolve (
      .mclk(mclk),
      .rst_n(rst_n),
      .fixed_speed_sel(speed_set),
      .fixed_full_sel(duplex_set),
      .phy_link(phy_link),
      .partner_negotiates(partner_negotiates),
      .partner_abil(partner_abil),
      .idle_is_100(idle_is_100),
      .cfg(cfg.resolver)
   );

   function automatic logic [AW-1:0] idx_of(input logic [47:0] a);
      return a[AW-1:0];
   endfunction

   function automatic logic [TW-1:0] tag_of(input logic [47:0] a);
      return a[47:AW];
   endfunction

   function automatic logic is_group(input logic [47:0] a);
      return |(a & fwd_pkg::MULTICAST_MASK);
   endfunction

   wire [AW-1:0] dst_idx = idx_of(dst_q);
   wire [AW-1:0] src_idx = idx_of(src_q);
   wire dst_hit = (age_mem[dst_idx] != fwd_pkg::AGE_NONE) && (tag_mem[dst_idx] == tag_of(dst_q));
   wire [PW-1:0] dst_port = port_mem[dst_idx];
   wire is_multicast = is_group(dst_q);
   // A group address names no single station, so it is never learned
   wire learn_now = (state == fwd_pkg::ST_UPDATE) && !bad_q && !is_group(src_q);
   wire [PORTS-1:0] in_bit = PORTS'(1) << port_q;
   wire [PORTS-1:0] all_ports = {PORTS{1'b1}};
   wire [PORTS-1:0] next_mask =
      bad_q ? '0 :
      is_multicast ? all_ports :
      !dst_hit ? (all_ports & ~in_bit) :
      (dst_port == port_q) ? '0 :
      (PORTS'(1) << dst_port);
   wire tick_now = (tick_cnt == TICK_W'(AGE_TICK - 1));
   wire accept = (state == fwd_pkg::ST_IDLE) && frame_done;

   always_comb begin
      case (state)
         fwd_pkg::ST_IDLE: next_state = frame_done ? fwd_pkg::ST_LOOKUP :
            (age_pend ? fwd_pkg::ST_SCRUB : fwd_pkg::ST_IDLE);
         fwd_pkg::ST_LOOKUP: next_state = fwd_pkg::ST_UPDATE;
         fwd_pkg::ST_UPDATE: next_state = fwd_pkg::ST_IDLE;
         fwd_pkg::ST_SCRUB: next_state = (scrub_idx == AW'(DEPTH - 1)) ? fwd_pkg::ST_IDLE : fwd_pkg::ST_SCRUB;
         default: next_state = fwd_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= fwd_pkg::ST_IDLE;
         tick_cnt <= '0;
         age_pend <= 1'b0;
         scrub_idx <= '0;
         dst_q <= '0;
         src_q <= '0;
         port_q <= '0;
         bad_q <= 1'b0;
         mask_q <= '0;
      end else begin
         state <= next_state;
         tick_cnt <= tick_now ? '0 : tick_cnt + TICK_W'(1);
         // A tick during a scrub pass is absorbed by that pass unless it lands on the last entry, so aging never stalls frames long
         if (tick_now) begin
            age_pend <= 1'b1;
         end else if (state == fwd_pkg::ST_SCRUB && next_state == fwd_pkg::ST_IDLE) begin
            age_pend <= 1'b0;
         end
         scrub_idx <= (state == fwd_pkg::ST_SCRUB) ? scrub_idx + AW'(1) : '0;
         if (accept) begin
            dst_q <= frame_dst;
            src_q <= frame_src;
            port_q <= frame_port;
            bad_q <= frame_bad;
         end
         if (state == fwd_pkg::ST_LOOKUP) begin
            mask_q <= next_mask;
         end
      end
   end

   // Age counters clear at reset; tags and ports are only meaningful with a nonzero age
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            age_mem[i] <= fwd_pkg::AGE_NONE;
         end
      end else if (learn_now) begin
         age_mem[src_idx] <= fwd_pkg::AGE_FRESH;
      end else if (state == fwd_pkg::ST_LOOKUP && dst_hit && !is_multicast) begin
         age_mem[dst_idx] <= fwd_pkg::AGE_FRESH;
      end else if (state == fwd_pkg::ST_SCRUB && age_mem[scrub_idx] != fwd_pkg::AGE_NONE) begin
         age_mem[scrub_idx] <= age_mem[scrub_idx] - 2'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (learn_now) begin
         tag_mem[src_idx] <= tag_of(src_q);
         port_mem[src_idx] <= port_q;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_s1 <= '0; tx_s2 <= '0; rx_s1 <= '0; rx_s2 <= '0;
         for (int p = 0; p < PORTS; p++) begin
            act_cnt[p] <= '0;
         end
      end else begin
         tx_s1 <= tx_frame; tx_s2 <= tx_s1;
         rx_s1 <= rx_frame; rx_s2 <= rx_s1;
         for (int p = 0; p < PORTS; p++) begin
            // Stretch short frames so the indicator is visible
            if (tx_s2[p] | rx_s2[p]) begin
               act_cnt[p] <= ACT_W'(ACT_HOLD);
            end else if (act_cnt[p] != '0) begin
               act_cnt[p] <= act_cnt[p] - ACT_W'(1);
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         frame_ready <= 1'b0;
         fwd_valid <= 1'b0;
         fwd_mask <= '0;
         link_up_indicator <= '0;
         activity_indicator <= '0;
         duplex_indicator <= '0;
         speed_indicator <= '0;
         table_busy <= 1'b0;
      end else begin
         frame_ready <= (next_state == fwd_pkg::ST_IDLE);
         fwd_valid <= (state == fwd_pkg::ST_UPDATE);
         fwd_mask <= (state == fwd_pkg::ST_UPDATE) ? mask_q : '0;
         link_up_indicator <= cfg.link_up;
         for (int p = 0; p < PORTS; p++) begin
            activity_indicator[p] <= (act_cnt[p] != '0) && cfg.link_up[p];
         end
         duplex_indicator <= cfg.full_duplex;
         speed_indicator <= cfg.speed_100;
         table_busy <= (next_state == fwd_pkg::ST_SCRUB);
      end
   end
endmodule
`default_nettype wire

// ===== fwd_checker.sv
// Concurrent checks on the forwarding core top ports
`timescale 1ns/1ps
`default_nettype none
module fwd_checker #(parameter int PORTS = 16) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic frame_done,
   input wire logic frame_bad,
   input wire logic [47:0] frame_dst,
   input wire logic frame_ready,
   input wire logic fwd_valid,
   input wire logic [PORTS-1:0] fwd_mask,
   input wire logic [PORTS-1:0] fixed_speed_sel,
   input wire logic [PORTS-1:0] phy_link,
   input wire logic [PORTS-1:0] link_up_indicator,
   input wire logic [PORTS-1:0] speed_indicator,
   input wire logic table_busy
);
   logic [2:0] up_cnt;
   // Counts active edges since reset so the link check skips the pipeline refill
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         up_cnt <= '0;
      end else if (up_cnt != 3'h7) begin
         up_cnt <= up_cnt + 3'h1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence take_s;
      frame_done && frame_ready;
   endsequence
   sequence answer_s;
      !frame_ready ##1 !frame_ready ##1 (fwd_valid && frame_ready);
   endsequence
   a_answer_timing: assert property (take_s |=> answer_s)
      else $error("answer not three edges after take");
   a_mask_idle_zero: assert property (!fwd_valid |-> fwd_mask == '0)
      else $error("mask set outside valid");
   a_single_pulse: assert property (fwd_valid |=> !fwd_valid)
      else $error("valid longer than one cycle");
   a_bad_dropped: assert property (take_s ##0 frame_bad |-> ##3 fwd_mask == '0)
      else $error("bad frame forwarded");
   a_group_flood: assert property (take_s ##0 (!frame_bad && frame_dst[40]) |-> ##3 (&fwd_mask))
      else $error("group frame not sent everywhere");
   a_busy_refuses: assert property (table_busy |-> !frame_ready)
      else $error("ready during aging scan");
   a_link_follows: assert property ((up_cnt >= 3'h4) |-> link_up_indicator == $past(phy_link, 4))
      else $error("link indicator does not follow link");
   a_fixed_speed: assert property ((fixed_speed_sel[1] && phy_link[1])[*6] |-> speed_indicator[1])
      else $error("fixed port not shown at 100");
endmodule
bind learning_switch_forwarding fwd_checker #(.PORTS(PORTS)) chk (.mclk, .rst_n, .frame_done, .frame_bad,
   .frame_dst, .frame_ready, .fwd_valid, .fwd_mask, .fixed_speed_sel, .phy_link, .link_up_indicator,
   .speed_indicator, .table_busy);
`default_nettype wire

// ===== link_partner.sv
// Far-end station model: cable attach, negotiation abilities, idle speed
`timescale 1ns/1ps
`default_nettype none
module link_partner #(parameter int PORTS = 16, parameter int DLY = 3) (
   input wire logic mclk,
   input wire logic [PORTS-1:0] attach,
   input wire logic [PORTS-1:0] negotiate,
   input wire logic [4*PORTS-1:0] abil,
   input wire logic [PORTS-1:0] fast,
   output logic [PORTS-1:0] phy_link,
   output logic [PORTS-1:0] partner_negotiates,
   output logic [4*PORTS-1:0] partner_abil,
   output logic [PORTS-1:0] idle_is_100
);
   // Link comes up DLY cycles after attach, like a slow partner
   logic [PORTS-1:0] dly [DLY];
   always_ff @(posedge mclk) begin
      dly[0] <= attach;
      for (int i = 1; i < DLY; i++) dly[i] <= dly[i-1];
   end
   assign phy_link = attach & dly[DLY-1];
   // A detached cable shows no negotiation and no idle signalling
   assign partner_negotiates = negotiate & attach;
   assign partner_abil = abil;
   assign idle_is_100 = fast & attach;
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the forwarding core with a link partner model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int P = 4;
   localparam logic [47:0] A = 48'h00000000000A, B = 48'h00000000000B, C = 48'h00000000000C;
   localparam logic [47:0] D = 48'h00000000000D, E = 48'h00000000000E;
   logic mclk = 0;
   logic rst_n = 0;
   logic frame_done = 0;
   logic frame_bad = 0;
   logic [1:0] frame_port = '0;
   logic [47:0] frame_dst = '0, frame_src = '0;
   logic [P-1:0] tx_frame = '0, rx_frame = '0, fixed_speed_sel = '0, fixed_full_sel = '0;
   logic [P-1:0] attach = '0, negotiate = '0, fast = '0;
   logic [4*P-1:0] abil = '0;
   logic frame_ready, fwd_valid, table_busy;
   logic [P-1:0] fwd_mask, phy_link, pneg, idle100, lk, act, dup, spd;
   logic [4*P-1:0] pabil;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;
   int wait_n = 0;
   int busy_len = 0;
   initial forever #5 mclk = ~mclk;
   link_partner #(.PORTS(P)) far (.mclk, .attach, .negotiate, .abil, .fast, .phy_link,
      .partner_negotiates(pneg), .partner_abil(pabil), .idle_is_100(idle100));
   learning_switch_forwarding #(.PORTS(P), .DEPTH(16), .AGE_TICK(50), .ACT_HOLD(8)) dut (.mclk, .rst_n,
      .frame_done, .frame_bad, .frame_port, .frame_dst, .frame_src, .frame_ready, .fwd_valid, .fwd_mask,
      .tx_frame, .rx_frame, .fixed_speed_sel, .fixed_full_sel, .phy_link, .partner_negotiates(pneg),
      .partner_abil(pabil), .idle_is_100(idle100), .link_up_indicator(lk), .activity_indicator(act),
      .duplex_indicator(dup), .speed_indicator(spd), .table_busy);
   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One descriptor in, one mask out; ready is waited on so scans are respected
   task automatic send(input int port, input logic [47:0] dst, input logic [47:0] src, input logic bad,
         input logic [P-1:0] exp);
      int k;
      k = 0;
      while (frame_ready !== 1'b1 && k < 200) begin
         @(negedge mclk);
         k++;
      end
      frame_done = 1;
      frame_bad = bad;
      frame_port = port[1:0];
      frame_dst = dst;
      frame_src = src;
      @(negedge mclk);
      frame_done = 0;
      k = 0;
      while (fwd_valid !== 1'b1 && k < 8) begin
         @(negedge mclk);
         k++;
      end
      check("fwd_valid", fwd_valid, 1'h1);
      check("fwd_mask", fwd_mask, exp);
   endtask
   task automatic modes(input logic [P-1:0] s, l, d);
      repeat (20) @(negedge mclk);
      check("link", lk, l);
      check("speed", spd, s);
      check("duplex", dup, d);
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      rst_n = 1;
      @(negedge mclk);
      check("ready", frame_ready, 1'h1);
      send(0, B, A, 0, 4'hE);
      send(1, A, B, 0, 4'h1);
      send(0, A, C, 0, 4'h0);
      send(2, B, D, 1, 4'h0);
      send(3, D, A, 0, 4'h7);
      send(1, A, B, 0, 4'h8);
      send(2, 48'h01000000001C, E, 0, 4'hF);
      // Keep B busy while A sits idle long enough to age out
      for (int i = 0; i < 10; i++) begin
         repeat (30) @(negedge mclk);
         send(1, 48'hFFFFFFFFFFFF, B, 0, 4'hF);
      end
      send(0, B, C, 0, 4'h2);
      send(0, A, C, 0, 4'hE);
      send(2, C, E, 0, 4'h1);
      // An aging scan holds the engine for exactly one pass over the 16 entries
      while (table_busy !== 1'b1 && wait_n < 200) begin
         @(negedge mclk);
         wait_n++;
      end
      while (table_busy === 1'b1 && busy_len < 40) begin
         check("ready_in_scan", frame_ready, 1'h0);
         @(negedge mclk);
         busy_len++;
      end
      check("scan_len", busy_len, 8'h10);
      rst_n = 0;
      repeat (3) @(negedge mclk);
      rst_n = 1;
      @(negedge mclk);
      send(0, E, A, 0, 4'hE);
      negotiate = 4'h7;
      abil = 16'h036F;
      fast = 4'h8;
      attach = 4'hF;
      modes(4'hB, 4'hF, 4'h5);
      attach = 4'h0;
      modes(4'h0, 4'h0, 4'h0);
      negotiate = 4'h8;
      abil = 16'h1000;
      fast = 4'h0;
      fixed_speed_sel = 4'h6;
      fixed_full_sel = 4'h2;
      attach = 4'hF;
      modes(4'h6, 4'hF, 4'h2);
      rx_frame = 4'h2;
      tx_frame = 4'h4;
      repeat (2) @(negedge mclk);
      rx_frame = 4'h0;
      tx_frame = 4'h0;
      repeat (4) @(negedge mclk);
      check("activity", act, 4'h6);
      repeat (20) @(negedge mclk);
      check("activity_off", act, 4'h0);
      close_out();
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         close_out();
      end
   end
endmodule
`default_nettype wire
